// [core/qrsfm_pkg.sv]
// Shared constants and types for the quad rail sequencer and fault monitor
package qrsfm_pkg;

	localparam int NCH    = 4;
	localparam int LDO_CH = 3;

	localparam int CLK_HZ        = 10_000_000;
	localparam int CYC_PER_US    = CLK_HZ / 1_000_000;
	localparam int SS_SW_US      = 3500;
	localparam int SS_LDO_US     = 500;
	localparam int PG_DLY_US     = 100;
	localparam int DEGLITCH_US   = 10;
	localparam int LIM_MS        = 10;
	localparam int RETRY_MS      = 100;
	localparam int SS_SW_CYC     = SS_SW_US * CYC_PER_US;
	localparam int SS_LDO_CYC    = SS_LDO_US * CYC_PER_US;
	localparam int PG_DLY_CYC    = PG_DLY_US * CYC_PER_US;
	localparam int DEGLITCH_CYC  = DEGLITCH_US * CYC_PER_US;
	localparam int LIM_CYC       = LIM_MS * 1000 * CYC_PER_US;
	localparam int RETRY_CYC     = RETRY_MS * 1000 * CYC_PER_US;

	localparam int CNT_W = 20;
	localparam int PG_W  = 10;
	localparam int DG_W  = 7;

	localparam int          ADR_W     = 8;
	localparam logic [7:0]  ADR_CTRL  = 8'h00;
	localparam logic [7:0]  ADR_STAT  = 8'h04;
	localparam logic [7:0]  ADR_FAULT = 8'h08;
	localparam logic [31:0] CTRL_RST  = 32'h0000_0000;
	localparam logic [15:0] FAULT_RST = 16'h0000;
	localparam int CTRL_PG_HOLD_BIT = 0;

	localparam int STAT_MODE_LSB = 0;
	localparam int STAT_RUN_LSB  = 8;
	localparam int STAT_GOOD_LSB = 12;
	localparam int STAT_POR_BIT  = 16;
	localparam int STAT_PG_BIT   = 17;
	localparam int FLT_OV_LSB    = 0;
	localparam int FLT_UV_LSB    = 4;
	localparam int FLT_LIM_LSB   = 8;
	localparam int FLT_HOT_LSB   = 12;

	localparam logic [1:0] MODE_STANDBY = 2'h0;
	localparam logic [1:0] MODE_NORMAL  = 2'h1;
	localparam logic [1:0] MODE_FAULT   = 2'h2;
	localparam logic [1:0] MODE_RAMP    = 2'h3;

	typedef enum logic [2:0] {
		ST_STANDBY,
		ST_RAMP,
		ST_RUN,
		ST_LIMIT,
		ST_RETRY,
		ST_THERMAL
	} qrsfm_state_e;

endpackage

// [core/qrsfm_flt_if.sv]
// Carrier between a raw fault indication and its glitch filter
`timescale 1ns/100ps
interface qrsfm_flt_if;
	logic raw;
	logic qual;
	modport filt (input raw, output qual);
	modport user (output raw, input qual);
endinterface

// [core/qrsfm_deglitch.sv]
// Symmetric glitch filter for one fault indication
`timescale 1ns/100ps
module qrsfm_deglitch (
	input  wire logic  clk_i,
	input  wire logic  rst_i,
	qrsfm_flt_if.filt  flt
);

	logic [qrsfm_pkg::DG_W-1:0] cnt_ff;
	logic                       qual_ff;

	// Both edges need the level to hold the full interval, so a fault clears as cleanly
	// as it sets
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_ff  <= '0;
			qual_ff <= 1'b0;
		end
		else if (flt.raw == qual_ff)
			cnt_ff <= '0;
		else if (cnt_ff == qrsfm_pkg::DG_W'(qrsfm_pkg::DEGLITCH_CYC - 1))
		begin
			cnt_ff  <= '0;
			qual_ff <= flt.raw;
		end
		else
			cnt_ff <= cnt_ff + 1'b1;
	end

	assign flt.qual = qual_ff;

endmodule // qrsfm_deglitch

// [core/qrsfm_top.sv]
// Quad rail sequencer and fault monitor with a Wishbone register slave
`timescale 1ns/100ps
module qrsfm_top #(
	parameter int SS_SW_CYC_P  = qrsfm_pkg::SS_SW_CYC,
	parameter int SS_LDO_CYC_P = qrsfm_pkg::SS_LDO_CYC,
	parameter int LIM_CYC_P    = qrsfm_pkg::LIM_CYC,
	parameter int RETRY_CYC_P  = qrsfm_pkg::RETRY_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        gate_drive_supply_level_i,
	input  wire logic        vin_ok_i,
	input  wire logic [3:0]  ch_vin_ok_i,
	input  wire logic [3:0]  en_i,
	input  wire logic [3:0]  over_threshold_event_i,
	input  wire logic [3:0]  under_threshold_event_i,
	input  wire logic [3:0]  peak_limit_i,
	input  wire logic [3:0]  short_trip_i,
	input  wire logic [3:0]  thermal_hot_i,
	output logic      [3:0]  ch_on_o,
	output logic      [3:0]  ramp_active_o,
	output logic      [3:0]  ov_reduce_o,
	output logic      [3:0]  uv_boost_o,
	output logic      [3:0]  cycle_limit_o,
	output logic             pgood_o,
	output logic             pgood_oe_o,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o
);

	localparam int NCH = qrsfm_pkg::NCH;

	logic             por_done_ff;
	logic             core_rst;
	logic [NCH-1:0]   good_vec;
	logic [NCH-1:0]   run_vec;
	logic [2*NCH-1:0] mode_vec;
	logic [NCH-1:0]   ov_set;
	logic [NCH-1:0]   uv_set;
	logic [NCH-1:0]   lim_set;
	logic [NCH-1:0]   hot_set;
	logic             all_good;
	logic [qrsfm_pkg::PG_W-1:0] pg_cnt_ff;
	logic             pg_ok_ff;
	logic [31:0]      ctrl_ff;
	logic [15:0]      fault_ff;
	logic [15:0]      fault_clr;
	logic [15:0]      fault_set;
	logic [31:0]      stat_w;
	logic             ack_ff;
	logic [31:0]      rdat_ff;
	logic             wb_req;
	logic             wb_wr;

	// Internal power-on reset: no rail runs until the gate drive supply is up, and once
	// seen it stays released so a droop on the check cannot restart the rails mid-run
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			por_done_ff <= 1'b0;
		else if (gate_drive_supply_level_i)
			por_done_ff <= 1'b1;
	end

	assign core_rst = rst_i | ~por_done_ff;

	for (genvar c = 0; c < NCH; c++)
	begin : g_ch
		localparam int SS_LEN = (c == qrsfm_pkg::LDO_CH) ? SS_LDO_CYC_P : SS_SW_CYC_P;

		qrsfm_pkg::qrsfm_state_e     st_ff;
		qrsfm_pkg::qrsfm_state_e     nxt_st;
		logic [qrsfm_pkg::CNT_W-1:0] cnt_ff;
		logic [qrsfm_pkg::CNT_W-1:0] nxt_cnt;
		logic                        input_ok;
		logic                        regulated;
		logic                        good;
		logic                        running;
		logic [1:0]                  mode;
		logic                        on_ff;
		logic                        ramp_ff;
		logic                        reduce_ff;
		logic                        boost_ff;
		logic                        limit_ff;

		qrsfm_flt_if ov_if ();
		qrsfm_flt_if uv_if ();
		qrsfm_flt_if lim_if ();

		assign ov_if.raw  = over_threshold_event_i[c];
		assign uv_if.raw  = under_threshold_event_i[c];
		assign lim_if.raw = peak_limit_i[c];

		qrsfm_deglitch u_ov_flt (
			.clk_i (clk_i),
			.rst_i (core_rst),
			.flt   (ov_if.filt)
		);

		qrsfm_deglitch u_uv_flt (
			.clk_i (clk_i),
			.rst_i (core_rst),
			.flt   (uv_if.filt)
		);

		qrsfm_deglitch u_lim_flt (
			.clk_i (clk_i),
			.rst_i (core_rst),
			.flt   (lim_if.filt)
		);

		always_comb
		begin
			nxt_st  = st_ff;
			nxt_cnt = cnt_ff;
			if (!en_i[c])
			begin
				nxt_st  = qrsfm_pkg::ST_STANDBY;
				nxt_cnt = '0;
			end
			else if (thermal_hot_i[c])
			begin
				nxt_st  = qrsfm_pkg::ST_THERMAL;
				nxt_cnt = '0;
			end
			else
			begin
				unique case (st_ff)
					qrsfm_pkg::ST_STANDBY:
					begin
						nxt_st  = qrsfm_pkg::ST_RAMP;
						nxt_cnt = '0;
					end
					qrsfm_pkg::ST_RAMP:
					begin
						if (short_trip_i[c])
						begin
							nxt_st  = qrsfm_pkg::ST_RETRY;
							nxt_cnt = '0;
						end
						else if (cnt_ff == qrsfm_pkg::CNT_W'(SS_LEN - 1))
						begin
							nxt_st  = qrsfm_pkg::ST_RUN;
							nxt_cnt = '0;
						end
						else
							nxt_cnt = cnt_ff + 1'b1;
					end
					qrsfm_pkg::ST_RUN:
					begin
						if (short_trip_i[c])
						begin
							nxt_st  = qrsfm_pkg::ST_RETRY;
							nxt_cnt = '0;
						end
						else if (peak_limit_i[c])
						begin
							nxt_st  = qrsfm_pkg::ST_LIMIT;
							nxt_cnt = '0;
						end
					end
					qrsfm_pkg::ST_LIMIT:
					begin
						if (short_trip_i[c] || cnt_ff == qrsfm_pkg::CNT_W'(LIM_CYC_P - 1))
						begin
							nxt_st  = qrsfm_pkg::ST_RETRY;
							nxt_cnt = '0;
						end
						else if (!peak_limit_i[c])
						begin
							nxt_st  = qrsfm_pkg::ST_RUN;
							nxt_cnt = '0;
						end
						else
							nxt_cnt = cnt_ff + 1'b1;
					end
					qrsfm_pkg::ST_RETRY:
					begin
						if (cnt_ff == qrsfm_pkg::CNT_W'(RETRY_CYC_P - 1))
						begin
							nxt_st  = qrsfm_pkg::ST_RAMP;
							nxt_cnt = '0;
						end
						else
							nxt_cnt = cnt_ff + 1'b1;
					end
					qrsfm_pkg::ST_THERMAL:
					begin
						nxt_st  = qrsfm_pkg::ST_RAMP;
						nxt_cnt = '0;
					end
					default:
					begin
						nxt_st  = qrsfm_pkg::ST_STANDBY;
						nxt_cnt = '0;
					end
				endcase
			end
		end

		always_ff @(posedge clk_i)
		begin
			if (core_rst)
			begin
				st_ff  <= qrsfm_pkg::ST_STANDBY;
				cnt_ff <= '0;
			end
			else
			begin
				st_ff  <= nxt_st;
				cnt_ff <= nxt_cnt;
			end
		end

		// Overvoltage and undervoltage do not move the state: the channel keeps
		// regulating, only power good, the drive mode and the fault flags react
		assign running   = (st_ff == qrsfm_pkg::ST_RAMP) || (st_ff == qrsfm_pkg::ST_RUN) ||
				(st_ff == qrsfm_pkg::ST_LIMIT);
		assign input_ok  = vin_ok_i & ch_vin_ok_i[c];
		assign regulated = input_ok & ~ov_if.qual & ~uv_if.qual;
		assign good      = en_i[c] & (st_ff == qrsfm_pkg::ST_RUN) & regulated &
				~lim_if.qual & ~thermal_hot_i[c];

		always_comb
		begin
			if (!en_i[c])
				mode = qrsfm_pkg::MODE_STANDBY;
			else if (st_ff == qrsfm_pkg::ST_RAMP)
				mode = qrsfm_pkg::MODE_RAMP;
			else if (good)
				mode = qrsfm_pkg::MODE_NORMAL;
			else
				mode = qrsfm_pkg::MODE_FAULT;
		end

		always_ff @(posedge clk_i)
		begin
			if (core_rst)
			begin
				on_ff     <= 1'b0;
				ramp_ff   <= 1'b0;
				reduce_ff <= 1'b0;
				boost_ff  <= 1'b0;
				limit_ff  <= 1'b0;
			end
			else
			begin
				on_ff     <= running & en_i[c];
				ramp_ff   <= (st_ff == qrsfm_pkg::ST_RAMP) & en_i[c];
				reduce_ff <= running & en_i[c] & ov_if.qual;
				boost_ff  <= running & en_i[c] & uv_if.qual & ~ov_if.qual;
				limit_ff  <= (st_ff == qrsfm_pkg::ST_LIMIT) & en_i[c];
			end
		end

		assign ch_on_o[c]       = on_ff;
		assign ramp_active_o[c] = ramp_ff;
		assign ov_reduce_o[c]   = reduce_ff;
		assign uv_boost_o[c]    = boost_ff;
		assign cycle_limit_o[c] = limit_ff;
		assign good_vec[c]      = good;
		assign run_vec[c]       = on_ff;
		assign mode_vec[2*c +: 2] = mode;
		assign ov_set[c]  = en_i[c] & ov_if.qual;
		assign uv_set[c]  = en_i[c] & uv_if.qual;
		assign lim_set[c] = en_i[c] & (nxt_st == qrsfm_pkg::ST_RETRY) &
				(st_ff != qrsfm_pkg::ST_RETRY);
		assign hot_set[c] = en_i[c] & thermal_hot_i[c] & (st_ff != qrsfm_pkg::ST_THERMAL);
	end

	// Power good qualification; any loss drops it at once, recovery waits the full delay
	assign all_good = (&good_vec) & ~ctrl_ff[qrsfm_pkg::CTRL_PG_HOLD_BIT];

	always_ff @(posedge clk_i)
	begin
		if (core_rst)
		begin
			pg_cnt_ff <= '0;
			pg_ok_ff  <= 1'b0;
		end
		else if (!all_good)
		begin
			pg_cnt_ff <= '0;
			pg_ok_ff  <= 1'b0;
		end
		else if (!pg_ok_ff)
		begin
			if (pg_cnt_ff == qrsfm_pkg::PG_W'(qrsfm_pkg::PG_DLY_CYC - 1))
				pg_ok_ff <= 1'b1;
			else
				pg_cnt_ff <= pg_cnt_ff + 1'b1;
		end
	end

	// Open drain: the pin is only ever pulled low
	assign pgood_o    = 1'b0;
	assign pgood_oe_o = ~pg_ok_ff;

	// Wishbone classic slave, single wait state on every access
	assign wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;
	assign wb_wr  = wb_req & wb_we_i;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_ff <= 1'b0;
		else
			ack_ff <= wb_req;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ctrl_ff <= qrsfm_pkg::CTRL_RST;
		else if (wb_wr && wb_adr_i == qrsfm_pkg::ADR_CTRL && wb_sel_i[0])
			ctrl_ff[qrsfm_pkg::CTRL_PG_HOLD_BIT] <= wb_dat_i[qrsfm_pkg::CTRL_PG_HOLD_BIT];
	end

	always_comb
	begin
		fault_clr = '0;
		if (wb_wr && wb_adr_i == qrsfm_pkg::ADR_FAULT)
		begin
			if (wb_sel_i[0])
				fault_clr[7:0] = wb_dat_i[7:0];
			if (wb_sel_i[1])
				fault_clr[15:8] = wb_dat_i[15:8];
		end
	end

	assign fault_set = {hot_set, lim_set, uv_set, ov_set};

	// A fault arriving in the clearing cycle survives the write-one-to-clear
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			fault_ff <= qrsfm_pkg::FAULT_RST;
		else
			fault_ff <= (fault_ff & ~fault_clr) | fault_set;
	end

	always_comb
	begin
		stat_w = '0;
		stat_w[qrsfm_pkg::STAT_MODE_LSB +: 2*NCH] = mode_vec;
		stat_w[qrsfm_pkg::STAT_RUN_LSB +: NCH]    = run_vec;
		stat_w[qrsfm_pkg::STAT_GOOD_LSB +: NCH]   = good_vec;
		stat_w[qrsfm_pkg::STAT_POR_BIT]           = por_done_ff;
		stat_w[qrsfm_pkg::STAT_PG_BIT]            = pg_ok_ff;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rdat_ff <= '0;
		else if (wb_req && !wb_we_i)
		begin
			unique case (wb_adr_i)
				qrsfm_pkg::ADR_CTRL:  rdat_ff <= ctrl_ff;
				qrsfm_pkg::ADR_STAT:  rdat_ff <= stat_w;
				qrsfm_pkg::ADR_FAULT: rdat_ff <= {16'h0000, fault_ff};
				default:              rdat_ff <= '0;
			endcase
		end
	end

	assign wb_ack_o = ack_ff;
	assign wb_dat_o = rdat_ff;

endmodule // qrsfm_top

// [bench/qrsfm_assertions.sv]
// Port-level properties of the quad rail sequencer
`timescale 1ns/100ps
module qrsfm_assertions #(
	parameter int SS_SW_CYC_P = 40,
	parameter int RETRY_CYC_P = 50
) (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       gate_drive_supply_level_i,
	input wire logic [3:0] en_i,
	input wire logic [3:0] over_threshold_event_i,
	input wire logic [3:0] under_threshold_event_i,
	input wire logic [3:0] peak_limit_i,
	input wire logic [3:0] ch_on_o,
	input wire logic [3:0] ramp_active_o,
	input wire logic [3:0] ov_reduce_o,
	input wire logic [3:0] uv_boost_o,
	input wire logic [3:0] cycle_limit_o,
	input wire logic       pgood_oe_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	logic        por_ff;
	logic        trip_ff;
	logic [20:0] ramp_ff;
	logic [20:0] up_ff;
	logic [20:0] off_ff;
	logic [7:0]  ov_ff;
	logic [7:0]  uv_ff;

	// The 21-bit counters are sized for the full retry count, not just the bench values
	always_ff @(posedge clk_i)
	begin
		por_ff <= !rst_i && (por_ff || gate_drive_supply_level_i);
		ramp_ff <= ramp_active_o[0] ? ramp_ff + 21'h1 : 21'h0;
		up_ff <= (ch_on_o == 4'hf && ramp_active_o == 4'h0) ? up_ff + 21'h1 : 21'h0;
		off_ff <= (ch_on_o[1] || rst_i) ? 21'h0 : off_ff + 21'h1;
		ov_ff <= over_threshold_event_i[0] ? ov_ff + 8'(ov_ff != 8'hff) : 8'h0;
		uv_ff <= under_threshold_event_i[0] ? uv_ff + 8'(uv_ff != 8'hff) : 8'h0;
		if (ch_on_o[1] || rst_i)
			trip_ff <= 1'b0;
		else if ($fell(ch_on_o[1]) && en_i[1] && $past(en_i[1]))
			trip_ff <= 1'b1;
	end

	property p_por_hold;
		!por_ff |-> ch_on_o == 4'h0;
	endproperty
	a_por_hold: assert property (p_por_hold) else $error("channel on before supply check");

	property p_stby;
		(ch_on_o & ~$past(en_i) & ~$past(en_i, 2)) == 4'h0;
	endproperty
	a_stby: assert property (p_stby) else $error("disabled channel still on");

	property p_ramp_len;
		$fell(ramp_active_o[0]) && en_i[0] && $past(en_i[0], 2)
			|-> ramp_ff >= SS_SW_CYC_P - 1 && ramp_ff <= SS_SW_CYC_P + 1;
	endproperty
	a_ramp_len: assert property (p_ramp_len) else $error("soft start length wrong");

	property p_pg_dly;
		$fell(pgood_oe_o) |-> up_ff >= 999 && en_i == 4'hf;
	endproperty
	a_pg_dly: assert property (p_pg_dly) else $error("power good released early");

	property p_ov_act;
		ov_ff > 8'd105 && en_i[0] |-> ch_on_o[0] && ov_reduce_o[0] && pgood_oe_o;
	endproperty
	a_ov_act: assert property (p_ov_act) else $error("overvoltage response wrong");

	property p_uv_act;
		uv_ff > 8'd105 && ov_ff == 8'h0 && en_i[0] |-> ch_on_o[0] && uv_boost_o[0] && pgood_oe_o;
	endproperty
	a_uv_act: assert property (p_uv_act) else $error("undervoltage response wrong");

	property p_limit;
		cycle_limit_o[1] |-> $past(peak_limit_i[1]) || $past(peak_limit_i[1], 2);
	endproperty
	a_limit: assert property (p_limit) else $error("limiting without peak current");

	property p_retry;
		$rose(ch_on_o[1]) && trip_ff |-> off_ff >= RETRY_CYC_P - 1 && ramp_active_o[1];
	endproperty
	a_retry: assert property (p_retry) else $error("retry too soon or without ramp");

	c_pg: cover property ($fell(pgood_oe_o));
	c_ov: cover property (ov_ff > 8'd105 && pgood_oe_o);
	c_rt: cover property ($rose(ch_on_o[1]) && trip_ff);
endmodule // qrsfm_assertions

bind qrsfm_top qrsfm_assertions #(.SS_SW_CYC_P(SS_SW_CYC_P), .RETRY_CYC_P(RETRY_CYC_P))
	u_qrsfm_assertions (.clk_i, .rst_i, .gate_drive_supply_level_i, .en_i,
	.over_threshold_event_i, .under_threshold_event_i, .peak_limit_i, .ch_on_o,
	.ramp_active_o, .ov_reduce_o, .uv_boost_o, .cycle_limit_o, .pgood_oe_o);

// [bench/qrsfm_host_model.sv]
// Host side: enable drivers and the pulled-up power good line
`timescale 1ns/100ps
module qrsfm_host_model (
	input  wire logic [3:0] en_req_i,
	input  wire logic       pgood_o,
	input  wire logic       pgood_oe_o,
	output logic      [3:0] en_o,
	output logic            pg_line_o
);
	// Each enable follows only its own request bit, so any order can be imposed
	assign en_o = en_req_i;
	// Open drain: the pull-up wins unless the device pulls low
	assign pg_line_o = pgood_oe_o ? pgood_o : 1'b1;
endmodule // qrsfm_host_model

// [bench/qrsfm_top_tb_top.sv]
// Self-checking bench for the quad rail sequencer
`timescale 1ns/100ps
module qrsfm_top_tb_top;
	logic        clk, rst, gd, cyc, stb, we, ack, pg, pg_oe, pg_line, vin;
	logic [3:0]  en_req, en, ov, uv, pk, hot, on, ramp, ovr, uvb, lim;
	logic [3:0]  cvin, trip, sel;
	logic [7:0]  adr;
	logic [31:0] wdat, rdat, q;
	int          bad_count, n_compared, t;

	// Short counts keep the run small; bench expectations use these values
	qrsfm_top #(.SS_SW_CYC_P(40), .SS_LDO_CYC_P(20), .LIM_CYC_P(30), .RETRY_CYC_P(50))
	u_qrsfm_top (.clk_i(clk), .rst_i(rst), .gate_drive_supply_level_i(gd), .vin_ok_i(vin),
		.ch_vin_ok_i(cvin), .en_i(en), .over_threshold_event_i(ov),
		.under_threshold_event_i(uv), .peak_limit_i(pk), .short_trip_i(trip),
		.thermal_hot_i(hot), .ch_on_o(on), .ramp_active_o(ramp), .ov_reduce_o(ovr),
		.uv_boost_o(uvb), .cycle_limit_o(lim), .pgood_o(pg), .pgood_oe_o(pg_oe),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
	qrsfm_host_model u_qrsfm_host_model (.en_req_i(en_req), .pgood_o(pg), .pgood_oe_o(pg_oe),
		.en_o(en), .pg_line_o(pg_line));

	initial
	begin
		clk = 1'b0;
		forever
			#50 clk = ~clk;
	end

	task automatic end_of_test;
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			bad_count++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		do
		begin
			@(posedge clk);
			k++;
		end while (ack !== 1'b1 && k < 20);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
		chk(k < 20, 1);
		if (k >= 20)
			end_of_test;
	endtask

	task automatic wait_pg(input logic lvl, input int lim);
		t = 0;
		while (pg_line !== lvl && t < lim)
		begin
			@(posedge clk);
			t++;
		end
		chk(t < lim, 1);
		if (t >= lim)
			end_of_test;
	endtask

	initial
	begin
		bad_count = 0;
		n_compared = 0;
		rst = 1'b1;
		{gd, cyc, stb, we, adr, wdat} = '0;
		{en_req, ov, uv, pk, hot, trip} = '0;
		vin = 1'b1;
		cvin = 4'hf;
		sel = 4'hf;
		tick(12);
		rst <= 1'b0;
		en_req <= 4'hf;
		tick(20);
		chk(on, 4'h0);
		gd <= 1'b1;
		wait_pg(1'b1, 2000);
		chk(t >= 1040 && t <= 1050, 1);
		chk(on, 4'hf);
		$display("test start-up done");
		for (int k = 0; k < 2; k++)
		begin
			ov <= (k == 0) ? 4'h1 : 4'h0;
			uv <= (k == 1) ? 4'h1 : 4'h0;
			tick(60);
			chk(pg_line, 1'b1);
			tick(60);
			chk(pg_line, 1'b0);
			chk({on[0], ovr[0], uvb[0]}, k ? 3'b101 : 3'b110);
			ov <= 4'h0;
			uv <= 4'h0;
			wait_pg(1'b1, 1300);
			chk(t >= 1099, 1);
		end
		$display("test threshold events done");
		pk <= 4'h2;
		tick(3);
		chk(lim[1], 1'b1);
		tick(40);
		chk({on[1], pg_line}, 2'b00);
		pk <= 4'h0;
		tick(30);
		chk(on[1], 1'b0);
		tick(20);
		chk({on[1], ramp[1]}, 2'b11);
		$display("test current limit done");
		hot <= 4'h8;
		tick(3);
		chk(on[3], 1'b0);
		hot <= 4'h0;
		tick(3);
		chk(ramp[3], 1'b1);
		en_req <= 4'hb;
		tick(3);
		chk({on[2], pg_line}, 2'b00);
		$display("test thermal and standby done");
		wb(1'b0, 8'h04, 32'h0);
		chk({q[16], q[11:8], q[5:4]}, 7'h6c);
		wb(1'b0, 8'h08, 32'h0);
		chk(q, 32'h8211);
		wb(1'b1, 8'h08, 32'hffff);
		wb(1'b0, 8'h08, 32'h0);
		chk(q, 32'h0);
		wb(1'b1, 8'h00, 32'h1);
		wb(1'b0, 8'h00, 32'h0);
		chk(q, 32'h1);
		sel <= 4'he;
		wb(1'b1, 8'h00, 32'h0);
		sel <= 4'hf;
		wb(1'b0, 8'h00, 32'h0);
		chk(q, 32'h1);
		wb(1'b1, 8'h00, 32'h0);
		wb(1'b0, 8'h10, 32'h0);
		chk(q, 32'h0);
		$display("test register access done");
		trip <= 4'h2;
		tick(3);
		chk(on[1], 1'b0);
		trip <= 4'h0;
		tick(60);
		chk({on[1], ramp[1]}, 2'b11);
		wb(1'b0, 8'h08, 32'h0);
		chk(q, 32'h200);
		$display("test short trip done");
		vin <= 1'b0;
		wb(1'b0, 8'h04, 32'h0);
		chk(q[15:0], 16'h0b8e);
		vin <= 1'b1;
		cvin <= 4'he;
		wb(1'b0, 8'h04, 32'h0);
		chk(q[15:0], 16'h8b4e);
		cvin <= 4'hf;
		wb(1'b0, 8'h04, 32'h0);
		chk(q[15:0], 16'h9b4d);
		$display("test input valid done");
		end_of_test;
	end
endmodule // qrsfm_top_tb_top
